// File: hw/dtc_pkg.sv
package dtc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00;  // initiator command bits
   localparam logic [7:0] OFF_MODE   = 8'h04;  // mode bits
   localparam logic [7:0] OFF_TCMD   = 8'h08;  // target command / last byte sent
   localparam logic [7:0] OFF_STAT   = 8'h0C;  // bus and dma status (read only)
   localparam logic [7:0] OFF_IRQST  = 8'h10;  // sticky events (read only)
   localparam logic [7:0] OFF_IRQEN  = 8'h14;  // event enables
   localparam logic [7:0] OFF_IRQCLR = 8'h18;  // write one to clear
   localparam logic [7:0] OFF_SDIR   = 8'h1C;  // start dma initiator receive
   // initiator command bits
   localparam int B_ADB   = 0;
   localparam int B_ATN   = 1;
   localparam int B_SEL   = 2;
   localparam int B_BSY   = 3;
   localparam int B_ACK   = 4;
   localparam int B_DIFF  = 5;
   localparam int B_RST   = 7;
   // mode bits
   localparam int B_ARBIT = 0;
   localparam int B_DMA   = 1;
   localparam int B_TGT   = 6;
   localparam int B_REV   = 7;
   // target command bits
   localparam int B_LBS   = 7;
   // status bits
   localparam int S_EOD   = 0;
   localparam int S_DRQ   = 1;
   localparam int S_PM    = 2;
   localparam int S_FREE  = 3;
   localparam int S_HOLD  = 4;
   // interrupt event bits
   localparam int E_EOD   = 0;
   localparam int E_LBS   = 1;
   localparam int E_FREE  = 2;
   localparam logic [7:0]  MODE_RST  = 8'h80;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam int          NEV       = 3;
endpackage

// File: hw/dtc_top.sv
// Summary of operation
// - single-ended select high runs single-ended; low runs differential-pair mode.
// - differential mode: busy, select, reset pins stop driving, inputs only.
// - initiator command register holds differential enable at bit 5.
// - target-side enable active exactly when target role and differential enable set.
// - initiator-side enable active when target role clear and differential enable set.
// - target role flag is mode register bit 6.
// - data-bus enable asserted when assert-data-bus and target role both set.
// - also asserted with assert-data-bus, phase match, not target, I/O low.
// - arbitration output asserted when arbitration set and bus free detected.
// - busy-drive output active exactly while device asserts busy.
// - select-drive output follows assert-select control.
// - reset-drive output follows assert-reset control.
// - single-ended mode keeps all transceiver controls working identically.
// - later revision sets target command bit 7 once last byte reaches bus.
// - original revision: dma_finished_flag only means last byte taken from DMA.
// - end-of-process sets dma_finished_flag, stops requests, keeps DMA mode set.
// - later revision withholds receive ACK until start-receive register written.
`timescale 1ns/1ns
`default_nettype none
module dtc_top (
   input  wire logic        hclk,                         // bus clock
   input  wire logic        hresetn,                      // async reset, low
   input  wire logic        hsel,                         // slave select
   input  wire logic [31:0] haddr,                        // address
   input  wire logic [1:0]  htrans,                       // transfer type
   input  wire logic        hwrite,                       // write
   input  wire logic [2:0]  hsize,                        // size
   input  wire logic [31:0] hwdata,                       // write data
   input  wire logic        hready,                       // bus ready
   output logic [31:0]      hrdata,                       // read data
   output logic             hreadyout,                    // slave ready
   output logic             hresp,                        // always okay
   input  wire logic        single_ended_select,          // pin, high = single ended
   input  wire logic        bsy_in,                       // busy pin level
   input  wire logic        sel_in,                       // select pin level
   input  wire logic        rst_in,                       // reset pin level
   input  wire logic        io_in,                        // I/O pin level
   input  wire logic        req_in,                       // REQ pin level
   input  wire logic        phase_match,                  // phase match from core
   input  wire logic        end_of_process_input,         // dma end pin
   input  wire logic        dma_byte_taken,               // core took a byte from dma
   input  wire logic        byte_on_bus,                  // core put a byte on the bus
   output logic             bsy_out,                      // busy pin drive
   output logic             bsy_oe,                       // busy pin enable
   output logic             sel_out,                      // select pin drive
   output logic             sel_oe,                       // select pin enable
   output logic             rst_out,                      // reset pin drive
   output logic             rst_oe,                       // reset pin enable
   output logic             ack_out,                      // ack drive
   output logic             dma_request,                  // dma request
   output logic             data_bus_driver_enable,       // data transceivers
   output logic             target_side_driver_enable,    // target transceivers
   output logic             initiator_side_driver_enable, // initiator transceivers
   output logic             arbitration_id_drive,         // id during arbitration
   output logic             busy_drive_output,            // busy transceiver
   output logic             select_drive_output,          // select transceiver
   output logic             bus_reset_drive_output,       // reset transceiver
   output logic             irq                           // level interrupt
);
   logic [7:0] cmd;
   logic [7:0] mode;
   logic       lbs;
   logic       eod;
   logic       hold_ack;
   logic       pend_last;
   localparam int NEV_W = dtc_pkg::NEV;
   logic [NEV_W-1:0] ev_st;
   logic [NEV_W-1:0] ev_en;
   logic [4:0] s1;
   logic [4:0] s2;
   logic       bus_free;
   logic       wr_ph;
   logic       rd_ph;
   logic [7:0] ph_addr;
   logic       eop_d;
   logic       eop_pulse;
   logic       free_d;
   logic [NEV_W-1:0] ev_set;
   logic [NEV_W-1:0] ev_clr;
   logic       se;
   logic       tgt;
   logic       diff;
   logic       wr_mode;
   logic       wr_tcmd;
   logic       wr_sdir;
   logic       wr_irqen;
   logic       wr_irqclr;

   // mode, busy, select, reset and end-of-process pins come from outside: two stages before any use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= 5'h0_0;
         s2 <= 5'h0_0;
      end else begin
         s1 <= {single_ended_select, bsy_in, sel_in, rst_in, end_of_process_input};
         s2 <= s1;
      end
   end

   assign se   = s2[4];
   assign tgt  = mode[dtc_pkg::B_TGT];
   assign diff = cmd[dtc_pkg::B_DIFF];
   assign bus_free  = !s2[3] && !s2[2];
   assign eop_pulse = s2[0] && !eop_d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // one strobe per writable register except the command register, high in the data phase of a write to it
   assign wr_mode   = wr_ph && hit(ph_addr, dtc_pkg::OFF_MODE);
   assign wr_tcmd   = wr_ph && hit(ph_addr, dtc_pkg::OFF_TCMD);
   assign wr_sdir   = wr_ph && hit(ph_addr, dtc_pkg::OFF_SDIR);
   assign wr_irqen  = wr_ph && hit(ph_addr, dtc_pkg::OFF_IRQEN);
   assign wr_irqclr = wr_ph && hit(ph_addr, dtc_pkg::OFF_IRQCLR);

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph   <= 1'b0;
         rd_ph   <= 1'b0;
         ph_addr <= 8'h00;
      end else if (hready) begin
         wr_ph   <= hsel && htrans[1] && hwrite;
         rd_ph   <= hsel && htrans[1] && !hwrite;
         ph_addr <= haddr[7:0];
      end
   end

   // control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd  <= 8'h00;
         mode <= dtc_pkg::MODE_RST;
      end else if (wr_ph) begin
         if (hit(ph_addr, dtc_pkg::OFF_CMD)) begin
            cmd <= hwdata[7:0];
         end else if (hit(ph_addr, dtc_pkg::OFF_MODE)) begin
            mode <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eop_d  <= 1'b0;
         // an idle bus is free: starting high keeps reset from posing as a free event
         free_d <= 1'b1;
      end else begin
         eop_d  <= s2[0];
         free_d <= bus_free;
      end
   end

   // dma end handling
   // dma_finished_flag
   // an end of process in the cycle of the clearing mode write still wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eod <= 1'b0;
      end else if (eop_pulse) begin
         eod <= 1'b1;
      end else if (wr_mode && !hwdata[dtc_pkg::B_DMA]) begin
         eod <= 1'b0;
      end
   end

   // original: eod only, no bus tracking
   // armed by end of process, fired by the next byte seen on the bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_last <= 1'b0;
      end else if (eop_pulse && mode[dtc_pkg::B_REV]) begin
         pend_last <= 1'b1;
      end else if (pend_last && byte_on_bus) begin
         pend_last <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lbs <= 1'b0;
      end else if (pend_last && byte_on_bus) begin
         lbs <= 1'b1;
      end else if (wr_tcmd) begin
         lbs <= 1'b0;
      end
   end

   // ack hold
   // only the later revision holds; the original lets one more ack slip out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_ack <= 1'b0;
      end else if (eop_pulse && mode[dtc_pkg::B_REV] && !tgt) begin
         hold_ack <= 1'b1;
      end else if (wr_sdir) begin
         hold_ack <= 1'b0;
      end
   end

   // interrupts: set wins over clear
   assign ev_set = {bus_free && !free_d, pend_last && byte_on_bus, eop_pulse};
   assign ev_clr = wr_irqclr ? hwdata[NEV_W-1:0] : '0;

   // sticky status; an event in the clearing cycle survives the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_st <= '0;
      end else begin
         ev_st <= ev_set | (ev_st & ~ev_clr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_en <= '0;
      end else if (wr_irqen) begin
         ev_en <= hwdata[NEV_W-1:0];
      end
   end

   // read data, registered one cycle after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= dtc_pkg::ZERO_WORD;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready && hsel && htrans[1] && !hwrite) begin
            if (hit(haddr[7:0], dtc_pkg::OFF_CMD)) begin
               hrdata <= {24'h00_0000, cmd};
            end else if (hit(haddr[7:0], dtc_pkg::OFF_MODE)) begin
               hrdata <= {24'h00_0000, mode};
            end else if (hit(haddr[7:0], dtc_pkg::OFF_TCMD)) begin
               hrdata <= {24'h00_0000, lbs, 7'h00};
            end else if (hit(haddr[7:0], dtc_pkg::OFF_STAT)) begin
               hrdata <= {27'h000_0000, hold_ack, bus_free, phase_match, dma_request, eod};
            end else if (hit(haddr[7:0], dtc_pkg::OFF_IRQST)) begin
               hrdata <= {29'h0000_0000, ev_st};
            end else if (hit(haddr[7:0], dtc_pkg::OFF_IRQEN)) begin
               hrdata <= {29'h0000_0000, ev_en};
            end else begin
               hrdata <= dtc_pkg::ZERO_WORD;
            end
         end
      end
   end

   // transceiver controls, all registered
   // same logic in both modes; registered
   // side enables ignore the mode pin: transceivers stay usable single ended
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         target_side_driver_enable    <= 1'b0;
         initiator_side_driver_enable <= 1'b0;
      end else begin
         target_side_driver_enable    <= tgt && diff;
         initiator_side_driver_enable <= !tgt && diff;
      end
   end

   // line drivers follow their command or mode bits, the synchronised bus-free state, phase match and the unsynchronised I/O pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_bus_driver_enable       <= 1'b0;
         arbitration_id_drive         <= 1'b0;
         busy_drive_output            <= 1'b0;
         select_drive_output          <= 1'b0;
         bus_reset_drive_output       <= 1'b0;
      end else begin
         data_bus_driver_enable <= cmd[dtc_pkg::B_ADB] &&
                                   (tgt || (phase_match && !io_in));
         arbitration_id_drive   <= mode[dtc_pkg::B_ARBIT] && bus_free;
         busy_drive_output      <= cmd[dtc_pkg::B_BSY];
         select_drive_output    <= cmd[dtc_pkg::B_SEL];
         bus_reset_drive_output <= cmd[dtc_pkg::B_RST];
      end
   end

   // direct pins; in differential mode they become inputs only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bsy_out <= 1'b0;
         sel_out <= 1'b0;
         rst_out <= 1'b0;
      end else begin
         bsy_out <= cmd[dtc_pkg::B_BSY];
         sel_out <= cmd[dtc_pkg::B_SEL];
         rst_out <= cmd[dtc_pkg::B_RST];
      end
   end

   // drive only single ended
   // enables use the synchronised mode pin, so a mode change settles in three edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bsy_oe <= 1'b0;
         sel_oe <= 1'b0;
         rst_oe <= 1'b0;
      end else begin
         bsy_oe <= se && cmd[dtc_pkg::B_BSY];
         sel_oe <= se && cmd[dtc_pkg::B_SEL];
         rst_oe <= se && cmd[dtc_pkg::B_RST];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_out <= 1'b0;
      end else begin
         ack_out <= cmd[dtc_pkg::B_ACK] && !hold_ack;
      end
   end

   // no requests after end
   // the pulse term cuts the request in the same edge that sets eod
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_request <= 1'b0;
      end else begin
         dma_request <= mode[dtc_pkg::B_DMA] && !eod && !eop_pulse && req_in
                        && !dma_byte_taken;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_st & ev_en);
      end
   end
endmodule
`default_nettype wire

// File: bench/dtc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dtc_assertions (
   input  wire logic        hclk, // bus clock
   input  wire logic        hresetn, // async reset, low
   input  wire logic        hsel, // slave select
   input  wire logic        hwrite, // write
   input  wire logic        hready, // bus ready
   input  wire logic        hresp, // response
   input  wire logic        hreadyout, // slave ready
   input  wire logic [31:0] haddr, // address
   input  wire logic [31:0] hwdata, // write data
   input  wire logic [1:0]  htrans, // transfer type
   input  wire logic        single_ended_select, // mode pin
   input  wire logic        bsy_in, // busy line
   input  wire logic        sel_in, // select line
   input  wire logic        end_of_process_input, // dma end pin
   input  wire logic        bsy_oe, // busy pin enable
   input  wire logic        sel_oe, // select pin enable
   input  wire logic        rst_oe, // reset pin enable
   input  wire logic        ack_out, // ack drive
   input  wire logic        dma_request, // dma request
   input  wire logic        target_side_driver_enable, // target side
   input  wire logic        initiator_side_driver_enable, // initiator side
   input  wire logic        arbitration_id_drive, // id drive
   input  wire logic        busy_drive_output, // busy driver
   input  wire logic        select_drive_output, // select driver
   input  wire logic        bus_reset_drive_output // reset driver
);
   logic [2:0] busy_cnt;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // address phase of a write to the command register, ending in its data phase
   sequence s_cmd_wr;
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == dtc_pkg::OFF_CMD ##1 1'b1;
   endsequence
   // saturating count of an occupied bus; long enough that the pin sync lag is over
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         busy_cnt <= 3'h0;
      else if (!(bsy_in || sel_in))
         busy_cnt <= 3'h0;
      else if (busy_cnt != 3'h7)
         busy_cnt <= busy_cnt + 3'h1;
   end
   a_bus_okay: assert property (!hresp && hreadyout)
      else $error("bus slave not ready or not okay");
   a_side_excl: assert property (!(target_side_driver_enable && initiator_side_driver_enable))
      else $error("both side enables high");
   a_diff_off: assert property (!single_ended_select [*6] |=> !bsy_oe && !sel_oe && !rst_oe)
      else $error("pin driven in differential mode");
   a_rst_follow: assert property ((s_cmd_wr ##0 hwdata[7]) |-> ##[1:3] bus_reset_drive_output)
      else $error("reset drive did not follow");
   a_sel_follow: assert property ((s_cmd_wr ##0 !hwdata[2]) |-> ##[1:3] !select_drive_output)
      else $error("select drive did not drop");
   a_busy_follow: assert property ((s_cmd_wr ##0 hwdata[3]) |-> ##[1:3] busy_drive_output)
      else $error("busy drive did not follow");
   a_diff_clear: assert property ((s_cmd_wr ##0 !hwdata[5]) |->
      ##[1:3] !target_side_driver_enable && !initiator_side_driver_enable)
      else $error("side enable without differential enable");
   a_ack_clear: assert property ((s_cmd_wr ##0 !hwdata[4]) |-> ##[1:3] !ack_out)
      else $error("ack stayed high");
   a_arb_free: assert property (busy_cnt == 3'h7 |-> !arbitration_id_drive)
      else $error("arbitration id on a busy bus");
   a_dma_stop: assert property ($rose(end_of_process_input) |-> ##6 !dma_request [*4])
      else $error("dma request after end of process");
endmodule
bind dtc_top dtc_assertions dtc_assertions_i (.*);
`default_nettype wire

// File: bench/dtc_xcvr_model.sv
`timescale 1ns/1ns
`default_nettype none
// external transceivers and the other bus devices; lines are wired-or, high = asserted
module dtc_xcvr_model (
   input  wire logic bsy_out, // busy pin
   input  wire logic bsy_oe, // busy pin enable
   input  wire logic sel_out, // select pin
   input  wire logic sel_oe, // select pin enable
   input  wire logic rst_out, // reset pin
   input  wire logic rst_oe, // reset pin enable
   input  wire logic busy_drive_output, // busy driver
   input  wire logic select_drive_output, // select driver
   input  wire logic bus_reset_drive_output, // reset driver
   input  wire logic far_bsy, // other devices busy
   input  wire logic far_sel, // other devices select
   input  wire logic far_rst, // other devices reset
   output logic      bsy_in, // busy receiver
   output logic      sel_in, // select receiver
   output logic      rst_in // reset receiver
);
   assign bsy_in = far_bsy | (bsy_oe & bsy_out) | busy_drive_output;
   assign sel_in = far_sel | (sel_oe & sel_out) | select_drive_output;
   assign rst_in = far_rst | (rst_oe & rst_out) | bus_reset_drive_output;
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        single_ended_select, bsy_in, sel_in, rst_in, io_in, req_in, phase_match;
   logic        end_of_process_input, dma_byte_taken, byte_on_bus, far_bsy, far_sel, far_rst;
   logic        bsy_out, bsy_oe, sel_out, sel_oe, rst_out, rst_oe, ack_out, dma_request, irq;
   logic        data_bus_driver_enable, target_side_driver_enable, initiator_side_driver_enable;
   logic        arbitration_id_drive, busy_drive_output, select_drive_output, bus_reset_drive_output;
   logic [15:0] lfsr;
   int          bad_count, tests_run, cmd, mode;
   assign hready = hreadyout;
   dtc_top dtc_top_i (.*);
   dtc_xcvr_model dtc_xcvr_model_i (.*);
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= 2'h2; hwrite <= w;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // bounded run; a hang counts as a failure
   initial begin
      tick(6000);
      bad_count++;
      summarize();
   end
   initial begin
      hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
      single_ended_select = 1; io_in = 0; req_in = 0; phase_match = 0; byte_on_bus = 0;
      end_of_process_input = 0; dma_byte_taken = 0; far_bsy = 0; far_sel = 0; far_rst = 0;
      lfsr = 16'h5EA9; bad_count = 0; tests_run = 0;
      tick(3);
      hresetn <= 1'b1;
      tick(1);
      bus(0, dtc_pkg::OFF_MODE, 0); `CHK("mode reset", 32'h0000_0080, rd)
      bus(0, dtc_pkg::OFF_CMD, 0); `CHK("cmd reset", 32'h0000_0000, rd)
      bus(0, 8'h40, 0); `CHK("unmapped", 32'h0000_0000, rd)
      for (int i = 0; i < 32; i++) begin
         lfsr = nxt(lfsr);
         cmd = {24'h00_0000, lfsr[7:0] & 8'hBF};
         mode = 32'h0000_0080 | (lfsr[8] ? 32'h0000_0040 : 32'h0000_0000) | lfsr[9];
         bus(1, dtc_pkg::OFF_CMD, cmd);
         bus(1, dtc_pkg::OFF_MODE, mode);
         single_ended_select <= lfsr[10]; phase_match <= lfsr[11]; io_in <= lfsr[12];
         far_bsy <= lfsr[13] & lfsr[14]; far_sel <= lfsr[15] & lfsr[13]; far_rst <= lfsr[14];
         tick(8);
         `CHK("target side", cmd[5] & mode[6], target_side_driver_enable)
         `CHK("initiator side", cmd[5] & !mode[6], initiator_side_driver_enable)
         `CHK("data bus", cmd[0] & (mode[6] | (phase_match & !io_in)), data_bus_driver_enable)
         `CHK("arbitration", mode[0] & !(far_bsy | cmd[3]) & !(far_sel | cmd[2]),
            arbitration_id_drive)
         `CHK("busy drive", cmd[3], busy_drive_output)
         `CHK("select drive", cmd[2], select_drive_output)
         `CHK("reset drive", cmd[7], bus_reset_drive_output)
         `CHK("ack", cmd[4], ack_out)
         if (!single_ended_select) `CHK("pin enables", 3'h0, {bsy_oe, sel_oe, rst_oe})
         else `CHK("pin enables", {cmd[3], cmd[2], cmd[7]}, {bsy_oe, sel_oe, rst_oe})
         `CHK("pin drives", {cmd[3], cmd[2], cmd[7]}, {bsy_out, sel_out, rst_out})
         bus(0, dtc_pkg::OFF_CMD, 0); `CHK("diff bit", cmd[5], rd[5])
      end
      // dma end: request stops, ack held until receive restarts, last byte flagged later
      bus(1, dtc_pkg::OFF_CMD, 0);
      bus(1, dtc_pkg::OFF_MODE, 32'h0000_0082);
      bus(1, dtc_pkg::OFF_IRQCLR, 32'h0000_0007);
      bus(1, dtc_pkg::OFF_IRQEN, 32'h0000_0001);
      req_in <= 1'b1;
      tick(8);
      `CHK("drq on", 1'b1, dma_request)
      `CHK("irq idle", 1'b0, irq)
      end_of_process_input <= 1'b1;
      tick(4);
      end_of_process_input <= 1'b0;
      tick(6);
      `CHK("drq off", 1'b0, dma_request)
      `CHK("irq eop", 1'b1, irq)
      bus(0, dtc_pkg::OFF_STAT, 0); `CHK("dma_finished_flag", 1'b1, rd[dtc_pkg::S_EOD])
      bus(0, dtc_pkg::OFF_MODE, 0); `CHK("dma mode kept", 1'b1, rd[dtc_pkg::B_DMA])
      bus(0, dtc_pkg::OFF_TCMD, 0); `CHK("not yet sent", 1'b0, rd[dtc_pkg::B_LBS])
      bus(1, dtc_pkg::OFF_CMD, 32'h0000_0010);
      tick(6);
      `CHK("ack held", 1'b0, ack_out)
      bus(1, dtc_pkg::OFF_SDIR, 0);
      tick(6);
      `CHK("ack freed", 1'b1, ack_out)
      byte_on_bus <= 1'b1;
      tick(1);
      byte_on_bus <= 1'b0;
      tick(4);
      bus(0, dtc_pkg::OFF_TCMD, 0); `CHK("last byte sent", 1'b1, rd[dtc_pkg::B_LBS])
      bus(0, dtc_pkg::OFF_IRQST, 0); `CHK("events", 2'h3, rd[1:0])
      bus(1, dtc_pkg::OFF_IRQEN, 0);
      tick(4);
      `CHK("irq masked", 1'b0, irq)
      bus(1, dtc_pkg::OFF_IRQEN, 32'h0000_0003);
      bus(1, dtc_pkg::OFF_IRQCLR, 32'h0000_0003);
      tick(4);
      `CHK("irq cleared", 1'b0, irq)
      bus(0, dtc_pkg::OFF_IRQST, 0); `CHK("events cleared", 2'h0, rd[1:0])
      // original revision: no last-byte tracking and no ack hold
      bus(1, dtc_pkg::OFF_MODE, 32'h0000_0000);
      bus(1, dtc_pkg::OFF_MODE, 32'h0000_0002);
      bus(1, dtc_pkg::OFF_TCMD, 0);
      end_of_process_input <= 1'b1;
      tick(4);
      end_of_process_input <= 1'b0;
      tick(6);
      `CHK("ack not held", 1'b1, ack_out)
      `CHK("drq off orig", 1'b0, dma_request)
      byte_on_bus <= 1'b1;
      tick(1);
      byte_on_bus <= 1'b0;
      tick(4);
      bus(0, dtc_pkg::OFF_STAT, 0); `CHK("dma_finished_flag orig", 1'b1, rd[dtc_pkg::S_EOD])
      bus(0, dtc_pkg::OFF_TCMD, 0); `CHK("no last byte", 1'b0, rd[dtc_pkg::B_LBS])
      // bus busy then free again raises the free event only
      far_bsy <= 1'b1; far_sel <= 1'b0;
      bus(1, dtc_pkg::OFF_IRQCLR, 32'h0000_0007);
      far_bsy <= 1'b0;
      tick(6);
      bus(0, dtc_pkg::OFF_IRQST, 0); `CHK("bus free event", 3'h4, rd[2:0])
      summarize();
   end
endmodule
`default_nettype wire
